// ===== rtl/fault_pkg.sv
package fault_pkg;
  // =====================================================
  // timing
  localparam int CLK_MHZ = 40;
  localparam int BLANK_NS = 5500;
  localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] BLANK_LAST = CNT_W'(BLANK_CYC - 1);
  // =====================================================
  // fault type codes driving the four-level output stage
  typedef enum logic [1:0] {
    TYPE_NONE = 2'b00,
    TYPE_OPEN = 2'b01,
    TYPE_OVERCUR = 2'b10,
    TYPE_OVERHEAT = 2'b11
  } fault_type_t;
  // =====================================================
  // latch bit positions
  localparam int BIT_OPEN = 0;
  localparam int BIT_OVERCUR = 1;
  localparam int BIT_HEAT = 2;
  localparam logic [2:0] LATCH_RST = 3'h0;
  localparam logic [3:0] PHASE_OFF = 4'h0;
endpackage

// ===== rtl/fault_if.sv
`timescale 1ns/1ps
interface fault_if;
  logic [2:0] latch;
  logic clear;
  modport owner (output latch, input clear);
  modport user (input latch, output clear);
endinterface

// ===== rtl/fault_latch.sv
`timescale 1ns/1ps
module fault_latch (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] detect,
  fault_if.owner lat
);
  logic [2:0] latch_q;
  // =====================================================
  // sticky latch; a fresh detect beats the clear so no event is lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_q <= fault_pkg::LATCH_RST;
    end else begin
      latch_q <= (lat.clear ? fault_pkg::LATCH_RST : latch_q) | detect;
    end
  end
  assign lat.latch = latch_q;
endmodule

// ===== rtl/stepper_driver_fault_latch.sv
`timescale 1ns/1ps
module stepper_driver_fault_latch (
  input wire logic clk,
  input wire logic rst,
  input wire logic system_clear_n,
  input wire logic enable,
  input wire logic [3:0] phase_req,
  input wire logic pwm_on,
  input wire logic flyback_seen,
  input wire logic current_ok,
  input wire logic over_current,
  input wire logic over_heat,
  output logic [3:0] phase_out,
  output logic any_fault_flag_n,
  output logic any_fault_oe,
  output logic [1:0] fault_type_level,
  output logic in_reset
);
  fault_if lat ();
  logic clear_n_q;
  logic pwm_q;
  logic off_flyback_q;
  logic [fault_pkg::CNT_W-1:0] blank_q;
  logic blank_done_q;
  logic [2:0] detect;
  // =====================================================
  // clear pulse: rising edge of system_clear_n after a low level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clear_n_q <= 1'b1;
    end else begin
      clear_n_q <= system_clear_n;
    end
  end
  assign lat.clear = system_clear_n & ~clear_n_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_reset <= 1'b1;
    end else begin
      in_reset <= ~system_clear_n;
    end
  end
  // =====================================================
  // pwm tracking and blanking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= pwm_on;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blank_q <= '0;
      blank_done_q <= 1'b0;
    end else if (pwm_on && !pwm_q) begin
      blank_q <= '0;
      blank_done_q <= 1'b0;
    end else if (pwm_on && !blank_done_q) begin
      if (blank_q == fault_pkg::BLANK_LAST) begin
        blank_done_q <= 1'b1;
      end
      blank_q <= blank_q + 1'b1;
    end else if (!pwm_on) begin
      blank_done_q <= 1'b0;
    end
  end
  // flyback must be seen somewhere inside each off period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      off_flyback_q <= 1'b0;
    end else if (pwm_on) begin
      off_flyback_q <= 1'b0;
    end else if (flyback_seen) begin
      off_flyback_q <= 1'b1;
    end
  end
  // =====================================================
  // detection; below the current floor the sense is unreliable so an open terminal is not judged
  always_comb begin
    detect = fault_pkg::LATCH_RST;
    detect[fault_pkg::BIT_OPEN] = pwm_on && !pwm_q && !off_flyback_q && !flyback_seen && current_ok;
    detect[fault_pkg::BIT_OVERCUR] = pwm_on && blank_done_q && over_current;
    detect[fault_pkg::BIT_HEAT] = over_heat;
  end
  fault_latch u_latch (
    .clk(clk),
    .rst(rst),
    .detect(detect),
    .lat(lat)
  );
  // =====================================================
  // outputs, all registered
  function automatic logic [1:0] worst(input logic [2:0] f);
    if (f[fault_pkg::BIT_HEAT]) begin
      return fault_pkg::TYPE_OVERHEAT;
    end else if (f[fault_pkg::BIT_OVERCUR]) begin
      return fault_pkg::TYPE_OVERCUR;
    end else if (f[fault_pkg::BIT_OPEN]) begin
      return fault_pkg::TYPE_OPEN;
    end
    return fault_pkg::TYPE_NONE;
  endfunction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      any_fault_flag_n <= 1'b1;
      any_fault_oe <= 1'b0;
      fault_type_level <= fault_pkg::TYPE_NONE;
    end else begin
      any_fault_flag_n <= ~|lat.latch;
      any_fault_oe <= |lat.latch;
      fault_type_level <= worst(lat.latch);
    end
  end
  // position lives in the sequencer upstream, so gating here keeps it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_out <= fault_pkg::PHASE_OFF;
    end else if (!enable || |lat.latch || !system_clear_n) begin
      phase_out <= fault_pkg::PHASE_OFF;
    end else begin
      phase_out <= phase_req;
    end
  end
  // =====================================================
  // helper: independent count of conduction cycles; saturates so long periods stay past blanking
  logic [fault_pkg::CNT_W-1:0] on_count_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      on_count_q <= '0;
    end else if (!pwm_on) begin
      on_count_q <= '0;
    end else if (on_count_q != '1) begin
      on_count_q <= on_count_q + 1'b1;
    end
  end
  // =====================================================
  // checks: fault flag and type outputs
  flag_follows_a: assert property (@(posedge clk) disable iff (rst)
    |lat.latch |=> !any_fault_flag_n && any_fault_oe)
    else $error("fault flag not raised");
  flag_release_a: assert property (@(posedge clk) disable iff (rst)
    !(|lat.latch) |=> any_fault_flag_n && !any_fault_oe && fault_type_level == fault_pkg::TYPE_NONE)
    else $error("fault flag raised with no fault");
  heat_type_a: assert property (@(posedge clk) disable iff (rst)
    lat.latch[fault_pkg::BIT_HEAT] |=> fault_type_level == fault_pkg::TYPE_OVERHEAT)
    else $error("overheat not reported");
  open_type_a: assert property (@(posedge clk) disable iff (rst)
    lat.latch[fault_pkg::BIT_OPEN] && !lat.latch[fault_pkg::BIT_OVERCUR] && !lat.latch[fault_pkg::BIT_HEAT]
    |=> fault_type_level == fault_pkg::TYPE_OPEN)
    else $error("open terminal not reported");
  worst_type_a: assert property (@(posedge clk) disable iff (rst)
    lat.latch[fault_pkg::BIT_OVERCUR] && !lat.latch[fault_pkg::BIT_HEAT]
    |=> fault_type_level == fault_pkg::TYPE_OVERCUR)
    else $error("wrong severity");
  // =====================================================
  // checks: latch and clear
  phases_off_a: assert property (@(posedge clk) disable iff (rst)
    |lat.latch |=> phase_out == fault_pkg::PHASE_OFF)
    else $error("phase on during fault");
  bits_sticky_a: assert property (@(posedge clk) disable iff (rst)
    !lat.clear |=> (lat.latch & $past(lat.latch)) == $past(lat.latch))
    else $error("latched fault bit lost");
  latch_hold_a: assert property (@(posedge clk) disable iff (rst)
    |lat.latch && !lat.clear |=> |lat.latch)
    else $error("latch dropped without clear");
  clear_empties_a: assert property (@(posedge clk) disable iff (rst)
    lat.clear && !(|detect) |=> lat.latch == fault_pkg::LATCH_RST)
    else $error("clear pulse left a fault");
  // =====================================================
  // checks: detection
  open_detect_a: assert property (@(posedge clk) disable iff (rst)
    detect[fault_pkg::BIT_OPEN] |=> lat.latch[fault_pkg::BIT_OPEN])
    else $error("open not latched");
  no_open_flyback_a: assert property (@(posedge clk) disable iff (rst)
    flyback_seen |-> !detect[fault_pkg::BIT_OPEN])
    else $error("open judged while flyback flows");
  low_current_a: assert property (@(posedge clk) disable iff (rst)
    !current_ok |-> !detect[fault_pkg::BIT_OPEN])
    else $error("open judged at low current");
  overcur_latch_a: assert property (@(posedge clk) disable iff (rst)
    detect[fault_pkg::BIT_OVERCUR] |=> lat.latch[fault_pkg::BIT_OVERCUR])
    else $error("overcurrent not latched");
  overcur_off_a: assert property (@(posedge clk) disable iff (rst)
    !pwm_on |-> !detect[fault_pkg::BIT_OVERCUR])
    else $error("overcurrent judged in off period");
  blank_window_a: assert property (@(posedge clk) disable iff (rst)
    pwm_on && !pwm_q |-> !detect[fault_pkg::BIT_OVERCUR] [*8])
    else $error("overcurrent in blanking");
  blank_span_a: assert property (@(posedge clk) disable iff (rst)
    detect[fault_pkg::BIT_OVERCUR] |-> on_count_q > fault_pkg::BLANK_LAST)
    else $error("overcurrent judged before blanking ended");
  blank_count_a: assert property (@(posedge clk) disable iff (rst)
    blank_done_q |-> blank_q == fault_pkg::BLANK_LAST + 1'b1)
    else $error("blanking ended at wrong count");
  heat_latch_a: assert property (@(posedge clk) disable iff (rst)
    over_heat |=> lat.latch[fault_pkg::BIT_HEAT])
    else $error("overheat not latched");
  // =====================================================
  // checks: reset and enable gating
  reset_hold_a: assert property (@(posedge clk) disable iff (rst)
    !system_clear_n |=> in_reset && phase_out == fault_pkg::PHASE_OFF)
    else $error("reset not held");
  reset_release_a: assert property (@(posedge clk) disable iff (rst)
    system_clear_n |=> !in_reset)
    else $error("reset held after release");
  enable_off_a: assert property (@(posedge clk) disable iff (rst)
    !enable |=> phase_out == fault_pkg::PHASE_OFF)
    else $error("phase on while disabled");
  pass_through_a: assert property (@(posedge clk) disable iff (rst)
    enable && system_clear_n && !(|lat.latch) |=> phase_out == $past(phase_req))
    else $error("phase pattern not passed through");
  // =====================================================
  // scenario covers
  open_seen_c: cover property (@(posedge clk) disable iff (rst) detect[fault_pkg::BIT_OPEN]);
  overcur_seen_c: cover property (@(posedge clk) disable iff (rst) detect[fault_pkg::BIT_OVERCUR]);
  heat_seen_c: cover property (@(posedge clk) disable iff (rst) detect[fault_pkg::BIT_HEAT]);
  clear_seen_c: cover property (@(posedge clk) disable iff (rst) |lat.latch && lat.clear);
  enable_gate_c: cover property (@(posedge clk) disable iff (rst) !enable && |phase_req);
endmodule

// ===== testbench/winding_model.sv
`timescale 1ns/1ps
// =====================================================
// motor windings: flyback only in off periods, and none while a terminal is open
module winding_model (
  input wire logic clk,
  input wire logic pwm_on,
  input wire logic open_term,
  input wire logic short_term,
  output logic flyback_seen,
  output logic over_current
);
  always_ff @(posedge clk) begin
    flyback_seen <= !pwm_on && !open_term;
    over_current <= pwm_on && short_term;
  end
endmodule

// ===== testbench/stepper_driver_fault_latch_tb_top.sv
`timescale 1ns/1ps
module stepper_driver_fault_latch_tb_top;
  logic clk, rst, system_clear_n, enable, pwm_on, current_ok, over_heat, open_term, short_term;
  logic flyback_seen, over_current, any_fault_flag_n, any_fault_oe, in_reset;
  logic [3:0] phase_req, phase_out;
  logic [1:0] fault_type_level;
  int n_errors = 0;
  int checked = 0;
  // row: {open, short, heat, expected type}
  logic [4:0] rows [6] = '{5'h00, 5'h11, 5'h0a, 5'h07, 5'h1a, 5'h1f};
  stepper_driver_fault_latch dut_u (.clk(clk), .rst(rst), .system_clear_n(system_clear_n), .enable(enable),
    .phase_req(phase_req), .pwm_on(pwm_on), .flyback_seen(flyback_seen), .current_ok(current_ok),
    .over_current(over_current), .over_heat(over_heat), .phase_out(phase_out),
    .any_fault_flag_n(any_fault_flag_n), .any_fault_oe(any_fault_oe),
    .fault_type_level(fault_type_level), .in_reset(in_reset));
  winding_model model_u (.clk(clk), .pwm_on(pwm_on), .open_term(open_term), .short_term(short_term),
    .flyback_seen(flyback_seen), .over_current(over_current));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // =====================================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic flags(input logic [1:0] t);
    chk(4'(any_fault_flag_n), 4'(t == 2'h0));
    chk(4'(any_fault_oe), 4'(t != 2'h0));
    chk(4'(fault_type_level), 4'(t));
  endtask
  // off period ends a conduction period, so open detection gets a fresh judgement
  task automatic chop(input int n);
    pwm_on = 1'b1;
    cyc(2);
    pwm_on = 1'b0;
    cyc(5);
    pwm_on = 1'b1;
    cyc(n);
  endtask
  task automatic clr;
    system_clear_n = 1'b0;
    cyc(3);
    chk(4'(in_reset), 4'h1);
    chk(phase_out, 4'h0);
    system_clear_n = 1'b1;
    cyc(3);
    chk(4'(in_reset), 4'h0);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // =====================================================
  // sequence
  initial begin
    {rst, system_clear_n, enable, pwm_on, current_ok, over_heat, open_term, short_term} = 8'he8;
    phase_req = 4'h9;
    cyc(20);
    flags(2'h0);
    rst = 1'b0;
    cyc(3);
    foreach (rows[i]) begin
      {open_term, short_term, over_heat} = rows[i][4:2];
      chop(230);
      flags(rows[i][1:0]);
      chk(phase_out, (rows[i][1:0] != 2'h0) ? 4'h0 : phase_req);
      {open_term, short_term, over_heat, pwm_on} = 4'h0;
      cyc(5);
      flags(rows[i][1:0]);
      clr;
      flags(2'h0);
    end
    // blanking restarts with every conduction period
    short_term = 1'b1;
    pwm_on = 1'b1;
    cyc(150);
    pwm_on = 1'b0;
    cyc(2);
    pwm_on = 1'b1;
    cyc(218);
    flags(2'h0);
    cyc(8);
    flags(2'h2);
    {short_term, pwm_on} = 2'h0;
    clr;
    // low current setting: open terminal goes unseen
    {current_ok, open_term} = 2'h1;
    chop(5);
    flags(2'h0);
    {current_ok, open_term, pwm_on} = 3'h4;
    enable = 1'b0;
    cyc(3);
    chk(phase_out, 4'h0);
    phase_req = 4'h6;
    enable = 1'b1; // no chopping soon after enable rises
    cyc(3);
    chk(phase_out, 4'h6);
    over_heat = 1'b1;
    cyc(4);
    flags(2'h3);
    chk(phase_out, 4'h0);
    over_heat = 1'b0;
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(3);
    flags(2'h0);
    end_sim;
  end
  // about 1900 cycles of tests; cut a hang well beyond that
  initial begin
    cyc(20000);
    n_errors++;
    end_sim;
  end
endmodule
